/* File: rtl/dcpm_map.vh */
`ifndef DCPM_MAP_VH
`define DCPM_MAP_VH

// Register offsets.
`define DCPM_ADDR_POWER_CONTROL     8'h87
`define DCPM_ADDR_OPTION_SELECT     8'h94
`define DCPM_ADDR_FAST_OSC_FINETUNE 8'hd7
`define DCPM_ADDR_CLOCK_CONTROL     8'hd8
`define DCPM_ADDR_SLOW_OSC_TRIM     8'hea
`define DCPM_ADDR_FAST_OSC_TRIM     8'hf6
`define DCPM_ADDR_AUX_CONTROL_TWO   8'hf7

// Field positions of clock_control.
`define DCPM_CC_SLOW_STOP   5
`define DCPM_CC_PERIPH_STOP 4
`define DCPM_CC_FAST_STOP   3
`define DCPM_CC_FAST_SEL    2
`define DCPM_CC_PSC_HI      1
`define DCPM_CC_PSC_LO      0

// Field positions of power_control.
`define DCPM_PC_SMOD 7
`define DCPM_PC_GF1  3
`define DCPM_PC_GF0  2
`define DCPM_PC_PD   1
`define DCPM_PC_IDL  0

// Field positions of option_select and aux_control_two.
`define DCPM_OPT_T3_SEL   6
`define DCPM_OPT_HI       6
`define DCPM_OPT_LO       2
`define DCPM_AUX_WDTE_HI  7
`define DCPM_AUX_WDTE_LO  6
`define DCPM_AUX_PWRSAV   5
`define DCPM_AUX_BANDGAP  4
`define DCPM_AUX_EEPTE    2

// Reset values, and the watchdog-enable code for always on.
`define DCPM_RST_SLOW_STOP   1'b1
`define DCPM_RST_PSC         2'b11
`define DCPM_RST_OPTION      5'h00
`define DCPM_RST_FINETUNE    5'h00
`define DCPM_RST_AUX_EEPTE   1'b1
`define DCPM_WDTE_ALWAYS     2'b11

// Prescaler encodings.
`define DCPM_PSC_DIV16 2'b00
`define DCPM_PSC_DIV4  2'b01
`define DCPM_PSC_DIV2  2'b10
`define DCPM_PSC_DIV1  2'b11

// Timing: rates in Hz, oscillator periods derived in clock cycles.
`define DCPM_MCLK_HZ      200000000
`define DCPM_FAST_OSC_HZ  16588800
`define DCPM_SLOW_OSC_HZ  131000
`define DCPM_PSC_LAST     4'hf
`define DCPM_PSC_DIV4_LAST 2'h3
`define DCPM_T3_SLOW_LAST 2'h3
`define DCPM_T3_FAST_LAST 9'h1ff

`endif

/* File: rtl/dcpm_ctrl.v */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "dcpm_map.vh"

module dcpm_ctrl (
  input  wire       MCLK,
  input  wire       RESETN,
  input  wire [7:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  input  wire [7:0] CFG_FAST_TRIM_WORD,
  input  wire [7:0] CFG_SLOW_TRIM_WORD,
  input  wire [1:0] EXT_INT_PIN,
  input  wire [1:0] EXT_INT_WAKE_EN,
  input  wire       PIN_CHANGE_WAKE,
  input  wire       TIMER3_IRQ,
  input  wire       INT_PENDING,
  input  wire       CKO_ENABLE,
  output reg  [4:0] MODE,
  output reg        FAST_OSC_EN,
  output reg        SLOW_OSC_EN,
  output reg  [6:0] FAST_TRIM,
  output reg  [4:0] FAST_FINETUNE,
  output reg  [4:0] SLOW_TRIM,
  output reg        CPU_CLK_EN,
  output reg        PERIPH_CLK_EN,
  output reg        TIMER3_CLK_EN,
  output reg        WDT_CLK_EN,
  output reg        CLK_OUT_HALF,
  output reg        BANDGAP_OUT_EN
);

  // Each oscillator is modelled as a tick enable at its nominal rate.
  localparam integer FAST_DIV   = `DCPM_MCLK_HZ / `DCPM_FAST_OSC_HZ;
  localparam integer SLOW_DIV   = `DCPM_MCLK_HZ / `DCPM_SLOW_OSC_HZ;
  localparam integer FAST_END   = FAST_DIV - 1;
  localparam integer SLOW_END   = SLOW_DIV - 1;
  localparam [10:0]  FAST_LAST  = FAST_END[10:0];
  localparam [10:0]  SLOW_LAST  = SLOW_END[10:0];
  localparam integer T3_SEL_BIT = `DCPM_OPT_T3_SEL - `DCPM_OPT_LO;

  localparam [4:0] ST_FAST = 5'h01;
  localparam [4:0] ST_SLOW = 5'h02;
  localparam [4:0] ST_IDLE = 5'h04;
  localparam [4:0] ST_HALT = 5'h08;
  localparam [4:0] ST_STOP = 5'h10;

  reg  [4:0]  state;
  reg  [4:0]  next_state;
  reg         slow_osc_stop;
  reg         periph_clk_stop_idle;
  reg         fast_osc_stop;
  reg         fast_clk_select;
  reg  [1:0]  sysclk_prescale;
  reg  [1:0]  active_prescale;
  reg  [2:0]  pctl_misc;
  reg         powerdown_request;
  reg         idle_request;
  reg  [4:0]  option_bits;
  reg  [4:0]  aux_bits;
  reg         boot_load;
  reg  [1:0]  pin_meta;
  reg  [1:0]  pin_sync;
  reg  [10:0] fast_cnt;
  reg  [10:0] slow_cnt;
  reg  [3:0]  psc_cnt;
  reg  [1:0]  t3_slow_cnt;
  reg  [8:0]  t3_fast_cnt;
  reg  [7:0]  next_rdata;

  wire        st_run    = state[0] | state[1];
  wire        wdt_alive = (aux_bits[4:3] == `DCPM_WDTE_ALWAYS);
  wire        fast_run  = ~fast_osc_stop & (st_run | state[2]);
  wire        slow_run  = ~state[4] | wdt_alive;
  wire        fast_tick = fast_run & (fast_cnt == FAST_LAST);
  wire        slow_tick = slow_run & (slow_cnt == SLOW_LAST);
  wire        src_tick  = fast_clk_select ? fast_tick : slow_tick;
  // A pin asks for wake-up while it is low and its wake enable is set.
  wire        pin_low   = |(~pin_sync & EXT_INT_WAKE_EN);
  wire        pin_wake  = pin_low | PIN_CHANGE_WAKE;
  wire        wr_pc     = WR & (ADDR == `DCPM_ADDR_POWER_CONTROL);
  wire        wr_cc     = WR & (ADDR == `DCPM_ADDR_CLOCK_CONTROL);
  wire        wd_fstop  = WDATA[`DCPM_CC_FAST_STOP];
  wire        wd_fsel   = WDATA[`DCPM_CC_FAST_SEL];
  wire        cc_both   = wd_fstop & wd_fsel;
  reg         sys_tick;
  // A wake source counts only in the mode that it is allowed to end.
  wire        wake_now  = (state[2] & (INT_PENDING | pin_wake)) |
                          (state[3] & (pin_wake | TIMER3_IRQ)) |
                          (state[4] & pin_wake);

  // Divider from the selected oscillator to the system clock enable.
  // The ratio in use changes only when the tick counter wraps, so no system
  // clock period is ever cut short while software changes the prescale.
  always @* begin
    case (active_prescale)
      `DCPM_PSC_DIV16: sys_tick = src_tick & (psc_cnt == `DCPM_PSC_LAST);
      `DCPM_PSC_DIV4:  sys_tick = src_tick & (psc_cnt[1:0] == `DCPM_PSC_DIV4_LAST);
      `DCPM_PSC_DIV2:  sys_tick = src_tick & psc_cnt[0];
      default:         sys_tick = src_tick;
    endcase
  end

  // Mode sequencer.
  // A power-down request beats an idle request when both are set.
  always @* begin
    next_state = state;
    case (state)
      ST_FAST, ST_SLOW: begin
        if (powerdown_request) begin
          next_state = slow_osc_stop ? ST_STOP : ST_HALT;
        end else if (idle_request) begin
          next_state = ST_IDLE;
        end else begin
          next_state = fast_clk_select ? ST_FAST : ST_SLOW;
        end
      end
      ST_IDLE: begin
        if (INT_PENDING | pin_wake) begin
          next_state = fast_clk_select ? ST_FAST : ST_SLOW;
        end
      end
      ST_HALT: begin
        if (pin_wake | TIMER3_IRQ) begin
          next_state = fast_clk_select ? ST_FAST : ST_SLOW;
        end
      end
      ST_STOP: begin
        if (pin_wake) begin
          next_state = fast_clk_select ? ST_FAST : ST_SLOW;
        end
      end
      default: next_state = ST_SLOW;
    endcase
  end

  // Read data mux.
  // Unmapped addresses read as zero.
  always @* begin
    next_rdata = 8'h00;
    if (ADDR == `DCPM_ADDR_POWER_CONTROL) begin
      next_rdata = {pctl_misc[2], 3'h0, pctl_misc[1:0], powerdown_request, idle_request};
    end else if (ADDR == `DCPM_ADDR_OPTION_SELECT) begin
      next_rdata = {1'b0, option_bits, 2'h0};
    end else if (ADDR == `DCPM_ADDR_FAST_OSC_FINETUNE) begin
      next_rdata = {3'h0, FAST_FINETUNE};
    end else if (ADDR == `DCPM_ADDR_CLOCK_CONTROL) begin
      next_rdata = {2'h0, slow_osc_stop, periph_clk_stop_idle, fast_osc_stop,
                    fast_clk_select, sysclk_prescale};
    end else if (ADDR == `DCPM_ADDR_SLOW_OSC_TRIM) begin
      next_rdata = {3'h0, SLOW_TRIM};
    end else if (ADDR == `DCPM_ADDR_FAST_OSC_TRIM) begin
      next_rdata = {1'b0, FAST_TRIM};
    end else if (ADDR == `DCPM_ADDR_AUX_CONTROL_TWO) begin
      next_rdata = {aux_bits[4:2], BANDGAP_OUT_EN, 1'b0, aux_bits[0], 2'h0};
    end
  end

  // Register bus and control registers.
  always @(posedge MCLK) begin
    if (!RESETN) begin
      RDATA                <= 8'h00;
      slow_osc_stop        <= `DCPM_RST_SLOW_STOP;
      periph_clk_stop_idle <= 1'b0;
      fast_osc_stop        <= 1'b0;
      fast_clk_select      <= 1'b0;
      sysclk_prescale      <= `DCPM_RST_PSC;
      pctl_misc            <= 3'h0;
      powerdown_request    <= 1'b0;
      idle_request         <= 1'b0;
      option_bits          <= `DCPM_RST_OPTION;
      aux_bits             <= {4'h0, `DCPM_RST_AUX_EEPTE};
      BANDGAP_OUT_EN       <= 1'b0;
      FAST_FINETUNE        <= `DCPM_RST_FINETUNE;
      FAST_TRIM            <= 7'h00;
      SLOW_TRIM            <= 5'h00;
      boot_load            <= 1'b1;
    end else begin
      RDATA     <= RD ? next_rdata : 8'h00;
      boot_load <= 1'b0;
      // The trims take the factory words in the first cycle after reset; a
      // software write in that same cycle loses to the load.
      if (boot_load) begin
        FAST_TRIM <= CFG_FAST_TRIM_WORD[6:0];
        SLOW_TRIM <= CFG_SLOW_TRIM_WORD[4:0];
      end else if (WR && ADDR == `DCPM_ADDR_FAST_OSC_TRIM) begin
        FAST_TRIM <= WDATA[6:0];
      end else if (WR && ADDR == `DCPM_ADDR_SLOW_OSC_TRIM) begin
        SLOW_TRIM <= WDATA[4:0];
      end
      if (WR && ADDR == `DCPM_ADDR_FAST_OSC_FINETUNE) begin
        FAST_FINETUNE <= WDATA[4:0];
      end
      if (WR && ADDR == `DCPM_ADDR_OPTION_SELECT) begin
        option_bits <= WDATA[`DCPM_OPT_HI:`DCPM_OPT_LO];
      end
      if (WR && ADDR == `DCPM_ADDR_AUX_CONTROL_TWO) begin
        aux_bits       <= {WDATA[`DCPM_AUX_WDTE_HI:`DCPM_AUX_WDTE_LO],
                           WDATA[`DCPM_AUX_PWRSAV], 1'b0, WDATA[`DCPM_AUX_EEPTE]};
        BANDGAP_OUT_EN <= WDATA[`DCPM_AUX_BANDGAP];
      end
      // Stop and select are gated so that the system clock never runs from an
      // oscillator that software has stopped.
      if (wr_cc) begin
        slow_osc_stop        <= WDATA[`DCPM_CC_SLOW_STOP];
        periph_clk_stop_idle <= WDATA[`DCPM_CC_PERIPH_STOP];
        sysclk_prescale      <= WDATA[`DCPM_CC_PSC_HI:`DCPM_CC_PSC_LO];
        if (state == ST_SLOW && !cc_both) begin
          fast_osc_stop <= wd_fstop;
        end
        if (!fast_osc_stop && !cc_both) begin
          fast_clk_select <= wd_fsel;
        end
      end
      // A power-down request is refused while an enabled pin already asks for
      // a wake-up, so the part never powers down on a low enabled pin. A write in the
      // same cycle as a wake-up wins, so a fresh request is not lost.
      if (wr_pc) begin
        pctl_misc         <= {WDATA[`DCPM_PC_SMOD], WDATA[`DCPM_PC_GF1], WDATA[`DCPM_PC_GF0]};
        powerdown_request <= WDATA[`DCPM_PC_PD] & ~pin_low;
        idle_request      <= WDATA[`DCPM_PC_IDL];
      end else if (wake_now) begin
        powerdown_request <= 1'b0;
        idle_request      <= 1'b0;
      end
    end
  end

  // Pin synchroniser for the external interrupt pins.
  // Only the second stage feeds logic, as the first may be metastable.
  always @(posedge MCLK) begin
    if (!RESETN) begin
      pin_meta <= 2'h3;
      pin_sync <= 2'h3;
    end else begin
      pin_meta <= EXT_INT_PIN;
      pin_sync <= pin_meta;
    end
  end

  // Oscillator models, prescaler and Timer3 source dividers.
  // A stopped oscillator holds its counter at zero and restarts with a full period.
  always @(posedge MCLK) begin
    if (!RESETN) begin
      state           <= ST_SLOW;
      fast_cnt        <= 11'h000;
      slow_cnt        <= 11'h000;
      psc_cnt         <= 4'h0;
      active_prescale <= `DCPM_RST_PSC;
      t3_slow_cnt     <= 2'h0;
      t3_fast_cnt     <= 9'h000;
    end else begin
      state <= next_state;
      if (!fast_run || fast_tick) begin
        fast_cnt <= 11'h000;
      end else begin
        fast_cnt <= fast_cnt + 11'h001;
      end
      if (!slow_run || slow_tick) begin
        slow_cnt <= 11'h000;
      end else begin
        slow_cnt <= slow_cnt + 11'h001;
      end
      if (src_tick) begin
        psc_cnt <= psc_cnt + 4'h1;
        if (psc_cnt == `DCPM_PSC_LAST) begin
          active_prescale <= sysclk_prescale;
        end
      end
      if (slow_tick) begin
        t3_slow_cnt <= t3_slow_cnt + 2'h1;
      end
      if (fast_tick) begin
        t3_fast_cnt <= t3_fast_cnt + 9'h001;
      end
    end
  end

  // Clock enables and gating per operating mode.
  // Every output is registered; the CPU, peripheral, Timer3 and watchdog enables are clean one-cycle pulses.
  always @(posedge MCLK) begin
    if (!RESETN) begin
      MODE          <= ST_SLOW;
      FAST_OSC_EN   <= 1'b1;
      SLOW_OSC_EN   <= 1'b1;
      CPU_CLK_EN    <= 1'b0;
      PERIPH_CLK_EN <= 1'b0;
      TIMER3_CLK_EN <= 1'b0;
      WDT_CLK_EN    <= 1'b0;
      CLK_OUT_HALF  <= 1'b0;
    end else begin
      MODE          <= state;
      FAST_OSC_EN   <= fast_run;
      SLOW_OSC_EN   <= slow_run;
      CPU_CLK_EN    <= sys_tick & st_run;
      PERIPH_CLK_EN <= sys_tick & (st_run | (state[2] & ~periph_clk_stop_idle));
      // Halt forces the slow source, as the fast oscillator is stopped there.
      if (option_bits[T3_SEL_BIT] && !state[3]) begin
        TIMER3_CLK_EN <= fast_tick & (t3_fast_cnt == `DCPM_T3_FAST_LAST);
      end else begin
        TIMER3_CLK_EN <= slow_tick & ~state[4] &
                         (t3_slow_cnt == `DCPM_T3_SLOW_LAST);
      end
      WDT_CLK_EN <= slow_tick & (st_run | wdt_alive);
      // The clock output is parked low while its port function is off.
      if (!CKO_ENABLE) begin
        CLK_OUT_HALF <= 1'b0;
      end else if (sys_tick && (st_run || state[2])) begin
        CLK_OUT_HALF <= ~CLK_OUT_HALF;
      end
    end
  end

endmodule // dcpm_ctrl
`default_nettype wire

/* File: test/dcpm_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module dcpm_ctrl_asserts (
  input wire logic       MCLK,
  input wire logic       RESETN,
  input wire logic [4:0] MODE,
  input wire logic       INT_PENDING,
  input wire logic [7:0] CFG_FAST_TRIM_WORD,
  input wire logic [7:0] CFG_SLOW_TRIM_WORD,
  input wire logic [6:0] FAST_TRIM,
  input wire logic [4:0] SLOW_TRIM,
  input wire logic       FAST_OSC_EN,
  input wire logic       CPU_CLK_EN,
  input wire logic       PERIPH_CLK_EN,
  input wire logic       TIMER3_CLK_EN
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  sequence s_fast3; MODE == 5'h01 [*3]; endsequence
  sequence s_low3; MODE[4:2] != 3'h0 [*3]; endsequence
  sequence s_halt3; MODE == 5'h08 [*3]; endsequence
  sequence s_stop3; MODE == 5'h10 [*3]; endsequence
  sequence s_idle_int; MODE == 5'h04 && INT_PENDING; endsequence
  a_reset_slow_mode: assert property ($rose(RESETN) |-> MODE == 5'h02)
    else $error("mode after reset is not slow");
  a_mode_one_hot: assert property ($onehot(MODE))
    else $error("mode is not one-hot");
  a_trim_load: assert property ($rose(RESETN) |-> ##2
    FAST_TRIM == CFG_FAST_TRIM_WORD[6:0] && SLOW_TRIM == CFG_SLOW_TRIM_WORD[4:0])
    else $error("trims not loaded after reset");
  a_fast_osc_run: assert property (s_fast3 |-> $past(FAST_OSC_EN))
    else $error("fast oscillator off in fast mode");
  a_cpu_clock_gated: assert property (s_low3 |-> $past(!CPU_CLK_EN))
    else $error("cpu clock runs in low power mode");
  a_halt_clocks_off: assert property (s_halt3 |-> $past(!FAST_OSC_EN && !PERIPH_CLK_EN))
    else $error("clocks run in halt mode");
  a_stop_clocks_off: assert property (s_stop3 |->
    $past(!FAST_OSC_EN && !PERIPH_CLK_EN && !TIMER3_CLK_EN))
    else $error("clocks run in stop mode");
  a_idle_int_wake: assert property (s_idle_int |-> ##[1:3] MODE != 5'h04)
    else $error("idle not left on interrupt");
endmodule // dcpm_ctrl_asserts
bind dcpm_ctrl dcpm_ctrl_asserts u_chk (.MCLK, .RESETN, .MODE, .INT_PENDING,
  .CFG_FAST_TRIM_WORD, .CFG_SLOW_TRIM_WORD, .FAST_TRIM, .SLOW_TRIM, .FAST_OSC_EN,
  .CPU_CLK_EN, .PERIPH_CLK_EN, .TIMER3_CLK_EN);
`default_nettype wire

/* File: test/dcpm_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dcpm_ctrl_tb;
  logic        MCLK, RESETN, WR, RD, CKO_ENABLE, FAST_OSC_EN, SLOW_OSC_EN, CPU_CLK_EN;
  logic        PERIPH_CLK_EN, TIMER3_CLK_EN, WDT_CLK_EN, CLK_OUT_HALF, BANDGAP_OUT_EN, cko_q;
  logic [7:0]  ADDR, WDATA, RDATA, CFG_FAST_TRIM_WORD, CFG_SLOW_TRIM_WORD, d;
  logic [1:0]  EXT_INT_PIN, EXT_INT_WAKE_EN;
  logic [2:0]  wk;
  logic [6:0]  FAST_TRIM;
  logic [4:0]  MODE, FAST_FINETUNE, SLOW_TRIM;
  logic [15:0] n;
  int          errors, comparisons;
  int          dv [4] = '{16, 4, 2, 1};
  logic [7:0]  rst_a [8] = '{8'hd8, 8'h87, 8'h94, 8'hd7, 8'hf7, 8'hea, 8'hf6, 8'h00};
  logic [7:0]  rst_v [8] = '{8'h23, 8'h00, 8'h00, 8'h00, 8'h04, 8'h1b, 8'h46, 8'h00};
  logic [7:0]  rw_v [8] = '{8'h00, 8'h00, 8'h7c, 8'h1f, 8'hf4, 8'h1f, 8'h7f, 8'h00};
  logic [7:0]  cc_w [6] = '{8'h2f, 8'h2b, 8'h2f, 8'h23, 8'h27, 8'h2f};
  logic [7:0]  cc_e [6] = '{8'h23, 8'h2b, 8'h2b, 8'h23, 8'h27, 8'h27};
  wire  [3:0]  pulses = {WDT_CLK_EN, TIMER3_CLK_EN, CLK_OUT_HALF ^ cko_q, CPU_CLK_EN};
  dcpm_ctrl uut (.MCLK, .RESETN, .ADDR, .WDATA, .WR, .RD, .RDATA, .CFG_FAST_TRIM_WORD,
    .CFG_SLOW_TRIM_WORD, .EXT_INT_PIN, .EXT_INT_WAKE_EN, .PIN_CHANGE_WAKE(wk[2]),
    .TIMER3_IRQ(wk[1]), .INT_PENDING(wk[0]), .CKO_ENABLE, .MODE, .FAST_OSC_EN, .SLOW_OSC_EN,
    .FAST_TRIM, .FAST_FINETUNE, .SLOW_TRIM, .CPU_CLK_EN, .PERIPH_CLK_EN, .TIMER3_CLK_EN,
    .WDT_CLK_EN, .CLK_OUT_HALF, .BANDGAP_OUT_EN);
  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end
  always @(posedge MCLK) cko_q <= CLK_OUT_HALF;
  task automatic complete_run();
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge MCLK);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic pulse(input int k);
    @(posedge MCLK);
    wk <= 3'(1 << k);
    repeat (4) @(posedge MCLK);
    wk <= 3'h0;
    wt(8);
  endtask
  // Counts cycles between two successive pulses of the chosen tick.
  task automatic measure(input int k);
    n = 16'h0;
    for (int i = 0; i < 20000 && pulses[k] !== 1'b1; i++) wt(1);
    do begin
      wt(1);
      n = n + 16'h1;
    end while (pulses[k] !== 1'b1 && n < 16'h4000);
  endtask
  initial begin
    #450000;
    errors++;
    complete_run();
  end
  initial begin
    {RESETN, WR, RD, wk, ADDR, WDATA, EXT_INT_WAKE_EN} = '0;
    {CKO_ENABLE, EXT_INT_PIN} = 3'h7;
    CFG_FAST_TRIM_WORD = 8'hc6;
    CFG_SLOW_TRIM_WORD = 8'h3b;
    repeat (4) @(posedge MCLK);
    RESETN <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(rst_a[i]);
      check("reset value", d, rst_v[i]);
    end
    check("reset mode", MODE, 5'h02);
    check("fast trim port", FAST_TRIM, 7'h46);
    for (int i = 2; i < 8; i++) begin
      wr(rst_a[i], 8'hff);
      rd(rst_a[i]);
      check("register write", d, rw_v[i]);
      if (i == 4) check("bandgap", BANDGAP_OUT_EN, 1'b1);
      if (i == 3) check("fine tune port", FAST_FINETUNE, 5'h1f);
      wr(rst_a[i], rst_v[i]);
    end
    for (int i = 0; i < 6; i++) begin
      wr(8'hd8, cc_w[i]);
      rd(8'hd8);
      check("clock control", d, cc_e[i]);
      check("fast osc enable", FAST_OSC_EN, !cc_e[i][3]);
    end
    wt(4);
    check("fast mode", MODE, 5'h01);
    for (int c = 0; c < 4; c++) begin
      wr(8'hd8, {6'h09, c[1:0]});
      wt(204);
      measure(0);
      check("system tick", n, 16'(12 * dv[c]));
      measure(1);
      check("clock out", n, 16'(12 * dv[c]));
    end
    @(posedge MCLK);
    CKO_ENABLE <= 1'b0;
    n = 16'h0;
    repeat (40) begin
      wt(1);
      if (CLK_OUT_HALF === 1'b1) n = n + 16'h1;
    end
    check("clock out off", n, 16'h0);
    @(posedge MCLK);
    CKO_ENABLE <= 1'b1;
    for (int t = 1; t >= 0; t--) begin
      wr(8'h94, {1'b0, t[0], 6'h00});
      wt(7000);
      measure(2);
      check("timer3 tick", n, t ? 16'd6144 : 16'd6104);
    end
    measure(3);
    check("watchdog tick", n, 16'd1526);
    for (int p = 0; p < 2; p++) begin
      wr(8'hd8, {3'h1, p[0], 4'h7});
      wr(8'h87, 8'h01);
      wt(6);
      check("idle mode", MODE, 5'h04);
      n = 16'h0;
      repeat (100) begin
        wt(1);
        if (PERIPH_CLK_EN === 1'b1) n = n + 16'h1;
      end
      check("periph gating", n == 16'h0, p[0]);
      pulse(0);
      check("idle wake", MODE, 5'h01);
      rd(8'h87);
      check("idle cleared", d, 8'h00);
    end
    wr(8'hd8, 8'h23);
    @(posedge MCLK);
    EXT_INT_PIN <= 2'b01;
    EXT_INT_WAKE_EN <= 2'b10;
    wt(8);
    wr(8'h87, 8'h02);
    rd(8'h87);
    check("pd refused", d, 8'h00);
    wt(4);
    check("no power down", MODE, 5'h02);
    @(posedge MCLK);
    EXT_INT_PIN <= 2'b11;
    EXT_INT_WAKE_EN <= 2'b01;
    wt(8);
    wr(8'hd8, 8'h03);
    wr(8'h87, 8'h02);
    wt(6);
    check("halt mode", MODE, 5'h08);
    check("slow osc halt", SLOW_OSC_EN, 1'b1);
    pulse(0);
    check("halt ignores int", MODE, 5'h08);
    pulse(1);
    check("halt wake", MODE, 5'h02);
    rd(8'h87);
    check("pd cleared", d, 8'h00);
    wr(8'hd8, 8'h23);
    for (int i = 0; i < 2; i++) begin
      wr(8'h87, 8'h02);
      wt(6);
      check("stop mode", MODE, 5'h10);
      check("slow osc stop", SLOW_OSC_EN, 1'b0);
      pulse(1);
      check("stop ignores timer", MODE, 5'h10);
      n = 16'h0;
      repeat (1600) begin
        wt(1);
        if (WDT_CLK_EN === 1'b1) n = n + 16'h1;
      end
      check("stop watchdog off", n, 16'h0);
      if (i == 0) begin
        @(posedge MCLK);
        EXT_INT_PIN <= 2'b10;
        wt(8);
        @(posedge MCLK);
        EXT_INT_PIN <= 2'b11;
        wt(8);
      end else begin
        wr(8'hf7, 8'hc4);
        measure(3);
        check("stop watchdog", n, 16'd1526);
        check("stop watchdog osc", SLOW_OSC_EN, 1'b1);
        wr(8'hf7, 8'h04);
        pulse(2);
      end
      check("stop wake", MODE, 5'h02);
    end
    @(posedge MCLK);
    CFG_FAST_TRIM_WORD <= 8'h2a;
    CFG_SLOW_TRIM_WORD <= 8'h15;
    RESETN <= 1'b0;
    wt(4);
    @(posedge MCLK);
    RESETN <= 1'b1;
    rd(8'hf6);
    check("fast trim reload", d, 8'h2a);
    rd(8'hea);
    check("slow trim reload", d, 8'h15);
    check("mode after reset", MODE, 5'h02);
    complete_run();
  end
endmodule // dcpm_ctrl_tb
`default_nettype wire
